// ### pkg/supply_fault_regs.vh
/*
 * Constants for the supply fault reset selection block: register offset,
 * field positions, reset values and widths.
 * Assumes inclusion by bare name from the design files.
 */
// How it works
// - Bits 15 to 12 of the selection register always read zero and writes to them are ignored.
// - With bit 11 set, a core supply under-voltage fault forces a power-on reset.
// - With bit 10 set, a core supply over-voltage fault forces a power-on reset.
// - With bit 9 set, an auxiliary supply under-voltage fault forces a power-on reset.
// - Every enable bit resets to zero, and a cleared bit lets its fault cause no reset.
// - Software can read back and rewrite enable bits 11 down to 0, which all clear to zero when an enabled fault raises a reset request.
// - Bits 8 down to 0 each enable a reset on one further supply fault.
`ifndef SUPPLY_FAULT_REGS_VH
`define SUPPLY_FAULT_REGS_VH

// ============================================================
// Register map
`define SFR_SELECT0_OFFSET   12'h428
`define SFR_SELECT0_RESET    16'h0000
`define SFR_WRITABLE_MASK    16'h0fff
`define SFR_ADDR_W           12
`define SFR_FAULT_W          12

// ============================================================
// Field positions
`define SFR_CORE_UV_BIT      11
`define SFR_CORE_OV_BIT      10
`define SFR_AUX_UV_BIT       9
`define SFR_AUX_OV_BIT       8
`define SFR_REFPRE_UV_BIT    7
`define SFR_PUMP_UV_BIT      6
`define SFR_PUMP_OV_BIT      5
`define SFR_ANA_UV_BIT       4
`define SFR_ANA_OV_BIT       3
`define SFR_DANA_UV_BIT      2
`define SFR_DANA_OV_BIT      1
`define SFR_BAT_OV_BIT       0

// ============================================================
// Timing
`define SFR_POR_PULSE_CYCLES 4'h4

`endif

// ### src/fault_sync.v
/*
 * Three-flop synchroniser for a bank of asynchronous fault levels.
 * A change is accepted once the second and third stages agree.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/10ps
`default_nettype none

module fault_sync #(
    parameter W = 12
) (
    input  wire         clock,
    input  wire         rst,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_out
);

// ============================================================
// Stages
reg [W-1:0] s1_r;
reg [W-1:0] s2_r;
reg [W-1:0] s3_r;

genvar g;
generate
    for (g = 0; g < W; g = g + 1) begin : bit_sync
        always @(posedge clock or posedge rst) begin
            if (rst) begin
                s1_r[g]     <= 1'b0;
                s2_r[g]     <= 1'b0;
                s3_r[g]     <= 1'b0;
                sync_out[g] <= 1'b0;
            end else begin
                s1_r[g] <= async_in[g];
                s2_r[g] <= s1_r[g];
                s3_r[g] <= s2_r[g];
                if (s2_r[g] == s3_r[g]) begin
                    sync_out[g] <= s3_r[g];
                end
            end
        end
    end
endgenerate

endmodule

`default_nettype wire

// ### src/supply_fault_reset_select.v
/*
 * Supply fault reset selection register with Avalon-MM slave access.
 * Each enable bit lets one supply fault force a power-on reset request.
 * Assumes fault levels arrive asynchronously from the supply detectors,
 * and that the reset request is fed back to the device reset tree.
 */
`timescale 1ns/10ps
`default_nettype none
`include "supply_fault_regs.vh"

module supply_fault_reset_select (
    input  wire        clock,
    input  wire        rst,
    input  wire [11:0] address,
    input  wire        read,
    input  wire        write,
    input  wire [3:0]  byteenable,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    output reg  [1:0]  response,
    input  wire [11:0] supply_fault,
    output reg  [11:0] fault_reset_cause,
    output wire        por_request
);

// ============================================================
// Register and bus state
reg  [15:0] select_r;
reg  [15:0] select_nxt;
reg         ack_r;
reg  [3:0]  por_cnt_r;
wire [11:0] fault_sync_lvl;
wire [11:0] hit;
wire        any_hit;
wire        sel_hit;
wire        req;

function [15:0] apply_bytes;
    input [15:0] cur;
    input [31:0] wd;
    input [3:0]  be;
    begin
        apply_bytes = cur;
        if (be[0]) begin
            apply_bytes[7:0] = wd[7:0];
        end
        if (be[1]) begin
            apply_bytes[15:8] = wd[15:8];
        end
        apply_bytes = apply_bytes & `SFR_WRITABLE_MASK;
    end
endfunction

// ============================================================
// Fault synchroniser
fault_sync #(
    .W (`SFR_FAULT_W)
) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (supply_fault),
    .sync_out (fault_sync_lvl)
);

// ============================================================
// Fault qualification
assign hit     = fault_sync_lvl & select_r[11:0];
assign any_hit = |hit;

// ============================================================
// Bus slave, one wait state
assign req         = read | write;
assign sel_hit     = (address == `SFR_SELECT0_OFFSET);
assign waitrequest = req & ~ack_r;

always @* begin
    select_nxt = select_r;
    if (write && ack_r && sel_hit) begin
        select_nxt = apply_bytes(select_r, writedata, byteenable);
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        select_r <= `SFR_SELECT0_RESET;
        ack_r    <= 1'b0;
        readdata <= 32'h00000000;
        response <= 2'h0;
    end else begin
        ack_r <= req & ~ack_r;
        if (por_cnt_r != 4'h0 || any_hit) begin
            select_r <= `SFR_SELECT0_RESET;
        end else begin
            select_r <= select_nxt;
        end
        if (req && !ack_r) begin
            response <= sel_hit ? 2'h0 : 2'h2;
            if (read && sel_hit) begin
                readdata <= {16'h0000, select_r & `SFR_WRITABLE_MASK};
            end else begin
                readdata <= 32'h00000000;
            end
        end
    end
end

// ============================================================
// Power-on reset request
assign por_request = (por_cnt_r != 4'h0);

always @(posedge clock or posedge rst) begin
    if (rst) begin
        por_cnt_r         <= 4'h0;
        fault_reset_cause <= 12'h000;
    end else begin
        if (any_hit && por_cnt_r == 4'h0) begin
            por_cnt_r         <= `SFR_POR_PULSE_CYCLES;
            fault_reset_cause <= hit;
        end else if (por_cnt_r != 4'h0) begin
            por_cnt_r <= por_cnt_r - 4'h1;
        end
    end
end

endmodule

`default_nettype wire

// ### tb/sfr_checker.sv
/* Port checker for supply_fault_reset_select.
   Bound to the block; one clock, rst async high. */
`timescale 1ns/10ps
`default_nettype none
module sfr_checker (
    input wire        clock,
    input wire        rst,
    input wire [11:0] address,
    input wire        read,
    input wire        write,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire [1:0]  response,
    input wire [11:0] fault_reset_cause,
    input wire        por_request
);
    // ====
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    wire done = (read | write) & ~waitrequest;
    wire hit  = address == 12'h428;
    AST_ACK: assert property ((read | write) && waitrequest |=> !waitrequest)
        else $error("no answer after one wait state");
    AST_RSV: assert property (done && read |-> readdata[31:12] == 20'h0)
        else $error("upper read bits not zero");
    AST_ERR: assert property (done && !hit |-> response == 2'h2)
        else $error("unmapped access not refused");
    AST_OK: assert property (done && hit |-> response == 2'h0)
        else $error("mapped access refused");
    AST_PULSE: assert property ($rose(por_request) |-> por_request[*4] ##1 !por_request)
        else $error("reset request length wrong");
    AST_CAUSE: assert property ($changed(fault_reset_cause) |-> $rose(por_request))
        else $error("cause changed without request");
    AST_NZ: assert property ($rose(por_request) |-> fault_reset_cause != 12'h0)
        else $error("request without enabled fault");
    AST_IDLE: assert property ($fell(rst) |-> !por_request && fault_reset_cause == 12'h0)
        else $error("not idle after reset");
endmodule
bind supply_fault_reset_select sfr_checker sfr_checker_i (.*);
`default_nettype wire

// ### tb/supply_fault_reset_select_test.sv
/* Self-checking bench for supply_fault_reset_select.
   Drives every port itself; header on include path. */
`timescale 1ns/10ps
`default_nettype none
module supply_fault_reset_select_test;
    logic        clock = 0, rst = 1, read = 0, write = 0, waitrequest, por_request;
    logic [11:0] address = 12'h0, supply_fault = 12'h0, fault_reset_cause, a;
    logic [3:0]  byteenable = 4'h0, b;
    logic [31:0] writedata = 32'h0, readdata, rd, d;
    logic [1:0]  response;
    logic [15:0] model = 16'h0;
    integer      seed = 32'h53af, bad_count = 0, tests_run = 0, cycles = 0, k, n;
    supply_fault_reset_select supply_fault_reset_select_i (.*);
    always #2.5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            finish_test;
        end
    end
    // ====
    // Tasks
    task check(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task bus(input logic w, input logic [11:0] ad, input logic [3:0] be, input logic [31:0] wd);
        @(posedge clock);
        read <= !w; write <= w; address <= ad; byteenable <= be; writedata <= wd;
        @(posedge clock);
        while (waitrequest !== 1'b0) @(posedge clock);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    function logic [15:0] merge(input logic [15:0] old, input logic [3:0] be, input logic [31:0] wd);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return ((old & ~m) | (wd[15:0] & m)) & 16'h0fff;
    endfunction
    task finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ====
    // Sequence
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, 12'h428, 4'hf, 32'h0);
        check("reset value", 32'h0, rd);
        for (n = 0; n < 16; n++) begin
            d = $random(seed);
            b = $random(seed);
            a = (n % 5 == 4) ? 12'h42c : 12'h428;
            bus(1'b1, a, b, d);
            if (a == 12'h428) model = merge(model, b, d);
            check("response", {30'h0, a == 12'h428 ? 2'h0 : 2'h2}, {30'h0, response});
            bus(1'b0, 12'h428, 4'hf, 32'h0);
            check("readback", {16'h0, model}, rd);
        end
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        bus(1'b0, 12'h428, 4'hf, 32'h0);
        check("reset again", 32'h0, rd);
        bus(1'b0, 12'h42c, 4'hf, 32'h0);
        check("unmapped data", 32'h0, rd);
        check("unmapped resp", 32'h2, {30'h0, response});
        bus(1'b1, 12'h428, 4'h3, 32'h0);
        supply_fault <= 12'hfff;
        repeat (12) @(posedge clock);
        check("disabled fault", 32'h0, {31'h0, por_request});
        for (k = 11; k >= 0; k--) begin
            supply_fault <= 12'h0;
            repeat (8) @(posedge clock);
            bus(1'b1, 12'h428, 4'h3, 32'h1 << k);
            supply_fault <= 12'(32'h1 << k) | 12'($random(seed));
            n = 0;
            while (por_request !== 1'b1 && n < 20) begin
                @(posedge clock);
                n++;
            end
            check("cause", 32'h1 << k, {20'h0, fault_reset_cause});
            repeat (6) @(posedge clock);
            bus(1'b0, 12'h428, 4'hf, 32'h0);
            check("cleared", 32'h0, rd);
        end
        finish_test;
    end
endmodule
`default_nettype wire
